// [verification/sem_mst.sv]
// Slot-layer master model driving the command layer strobes
`timescale 1ns/10ps

module sem_mst (
    // Clock
    input  wire logic clk,
    // Strobes to the device
    output logic      bus_reset,
    output logic      cmd_start,
    output logic      wr_bit_valid,
    output logic      wr_bit,
    output logic      rd_req,
    // Answer from the device
    input  wire logic rd_valid,
    input  wire logic rd_bit
);
    initial begin
        bus_reset    = 1'b0;
        cmd_start    = 1'b0;
        wr_bit_valid = 1'b0;
        wr_bit       = 1'b0;
        rd_req       = 1'b0;
    end

    task automatic breset();
        @(posedge clk) bus_reset <= 1'b1;
        @(posedge clk) bus_reset <= 1'b0;
        @(posedge clk);
    endtask : breset

    // Idle line shows the inverse, so stale values never pass
    task automatic wbit(input logic b);
        @(posedge clk) begin
            wr_bit_valid <= 1'b1;
            wr_bit       <= b;
        end
        @(posedge clk) begin
            wr_bit_valid <= 1'b0;
            wr_bit       <= ~b;
        end
    endtask : wbit

    task automatic wbyte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) wbit(b[i]);
    endtask : wbyte

    task automatic command(input logic [7:0] c);
        @(posedge clk) cmd_start <= 1'b1;
        @(posedge clk) cmd_start <= 1'b0;
        wbyte(c);
    endtask : command

    // Missing answer is returned as unknown
    task automatic rbit(output logic b);
        @(posedge clk) rd_req <= 1'b1;
        @(posedge clk) rd_req <= 1'b0;
        #1;
        b = (rd_valid === 1'b1) ? rd_bit : 1'bx;
    endtask : rbit
endmodule : sem_mst

// [verification/tb_top.sv]
// Directed testbench of the memory command layer
`timescale 1ns/10ps

module tb_top import sem_pkg::*; ();
    logic        clk;
    logic        rst;
    logic        ce;
    logic        speed_fast_set;
    logic        speed_regular_set;
    logic        bus_reset;
    logic        cmd_start;
    logic        wr_bit_valid;
    logic        wr_bit;
    logic        rd_req;
    logic        rd_valid;
    logic        rd_bit;
    logic        fast_speed_flag;
    logic        partial_byte_flag;
    logic        copy_accepted_flag;
    logic        copy_busy;
    int          n_mismatch;
    int          checks;
    int          cyc;
    logic [15:0] crc;
    logic [7:0]  dat [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};

    sem_core #(.COPY_LIMIT(400)) u_dut (
        .clk(clk), .rst(rst), .ce(ce), .bus_reset(bus_reset), .cmd_start(cmd_start),
        .wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_bit(rd_bit), .speed_fast_set(speed_fast_set),
        .speed_regular_set(speed_regular_set), .fast_speed_flag(fast_speed_flag),
        .partial_byte_flag(partial_byte_flag), .copy_accepted_flag(copy_accepted_flag),
        .copy_busy(copy_busy));

    sem_mst u_mst (
        .clk(clk), .bus_reset(bus_reset), .cmd_start(cmd_start),
        .wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_bit(rd_bit));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic rd_cmp(input string nm, input logic [7:0] e);
        logic [7:0] g;
        for (int i = 0; i < 8; i++) u_mst.rbit(g[i]);
        cmp(nm, {8'h00, e}, {8'h00, g});
    endtask : rd_cmp

    // Reflected CRC16, zero start, bit by bit
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_byte

    task automatic wr_crc(input logic [7:0] b);
        u_mst.wbyte(b);
        crc = crc_byte(crc, b);
    endtask : wr_crc

    // Hang guard, run needs about 1200 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        logic b;
        cyc               = 0;
        n_mismatch        = 0;
        checks            = 0;
        rst               = 1'b1;
        ce                = 1'b1;
        speed_fast_set    = 1'b0;
        speed_regular_set = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp("fast flag", 16'h0000, fast_speed_flag);
        cmp("busy", 16'h0000, copy_busy);
        cmp("accepted", 16'h0000, copy_accepted_flag);
        // Full write, address with upper bits set
        crc = CRC_RST;
        u_mst.command(CMD_WRITE_SP);
        crc = crc_byte(crc, CMD_WRITE_SP);
        wr_crc(8'h3C);
        wr_crc(8'hFF);
        for (int i = 0; i < 4; i++) wr_crc(dat[i]);
        rd_cmp("crc low", ~crc[7:0]);
        rd_cmp("crc high", ~crc[15:8]);
        u_mst.breset();
        u_mst.command(CMD_READ_SP);
        rd_cmp("ta low", 8'h3C);
        rd_cmp("ta high", 8'h01);
        rd_cmp("status", 8'h1F);
        for (int i = 0; i < 4; i++) rd_cmp("sp data", dat[i]);
        rd_cmp("past end", DATA_ONES);
        u_mst.breset();
        // Untruncated authorisation
        u_mst.command(CMD_COPY_SP);
        u_mst.wbyte(8'h3C);
        u_mst.wbyte(8'hFF);
        u_mst.wbyte(8'h1F);
        @(posedge clk);
        #1;
        cmp("refused busy", 16'h0000, copy_busy);
        cmp("refused aa", 16'h0000, copy_accepted_flag);
        u_mst.breset();
        u_mst.command(CMD_COPY_SP);
        u_mst.wbyte(8'h3C);
        u_mst.wbyte(8'h01);
        u_mst.wbyte(8'h1F);
        @(posedge clk);
        #1;
        cmp("copy busy", 16'h0001, copy_busy);
        cmp("copy aa", 16'h0001, copy_accepted_flag);
        for (int i = 0; i < 400 && copy_busy !== 1'b0; i++) @(posedge clk);
        cmp("copy end", 16'h0000, copy_busy);
        rd_cmp("alternation", 8'hAA);
        u_mst.breset();
        u_mst.command(CMD_READ_MEM);
        u_mst.wbyte(8'h3C);
        u_mst.wbyte(8'h01);
        for (int i = 0; i < 4; i++) rd_cmp("memory", dat[i]);
        u_mst.breset();
        u_mst.command(CMD_READ_SP);
        rd_cmp("rm ta low", 8'h3C);
        rd_cmp("rm ta high", 8'h01);
        rd_cmp("rm status", 8'h9F);
        u_mst.breset();
        // Last location, then ones
        u_mst.command(CMD_READ_MEM);
        u_mst.wbyte(8'hFF);
        u_mst.wbyte(8'hFF);
        for (int i = 0; i < 8; i++) u_mst.rbit(b);
        rd_cmp("mem end", DATA_ONES);
        u_mst.breset();
        // Incomplete last byte
        u_mst.command(CMD_WRITE_SP);
        u_mst.wbyte(8'h00);
        u_mst.wbyte(8'h00);
        u_mst.wbyte(8'h11);
        u_mst.wbit(1'b1);
        u_mst.wbit(1'b0);
        u_mst.breset();
        cmp("pf flag", 16'h0001, partial_byte_flag);
        cmp("aa cleared", 16'h0000, copy_accepted_flag);
        u_mst.command(CMD_READ_SP);
        rd_cmp("p ta low", 8'h00);
        rd_cmp("p ta high", 8'h00);
        rd_cmp("p status", 8'h20);
        rd_cmp("p data", 8'h11);
        u_mst.breset();
        // Unknown command locks out until reset
        u_mst.command(8'h33);
        u_mst.wbyte(8'h00);
        rd_cmp("unknown", DATA_ONES);
        u_mst.breset();
        u_mst.command(CMD_WRITE_SP);
        u_mst.wbyte(8'h00);
        u_mst.wbyte(8'h00);
        u_mst.wbyte(8'h11);
        // Flag settles only after the edge that takes the byte
        #1;
        cmp("pf cleared", 16'h0000, partial_byte_flag);
        u_mst.breset();
        // Speed flag set and cleared
        @(posedge clk) speed_fast_set <= 1'b1;
        @(posedge clk) speed_fast_set <= 1'b0;
        #1;
        cmp("fast set", 16'h0001, fast_speed_flag);
        @(posedge clk) speed_regular_set <= 1'b1;
        @(posedge clk) speed_regular_set <= 1'b0;
        #1;
        cmp("fast clear", 16'h0000, fast_speed_flag);
        // Low clock enable must ignore every strobe
        @(posedge clk) ce <= 1'b0;
        @(posedge clk) speed_fast_set <= 1'b1;
        @(posedge clk) speed_fast_set <= 1'b0;
        u_mst.command(CMD_WRITE_SP);
        u_mst.wbyte(8'h05);
        u_mst.wbyte(8'h00);
        @(posedge clk) ce <= 1'b1;
        #1;
        cmp("frozen fast", 16'h0000, fast_speed_flag);
        u_mst.command(CMD_READ_SP);
        rd_cmp("frozen ta low", 8'h00);
        rd_cmp("frozen ta high", 8'h00);
        rd_cmp("frozen status", 8'h00);
        // Mid-run reset returns to regular speed
        @(posedge clk) speed_fast_set <= 1'b1;
        @(posedge clk) begin
            speed_fast_set <= 1'b0;
            rst            <= 1'b1;
        end
        @(posedge clk) rst <= 1'b0;
        #1;
        cmp("reset fast", 16'h0000, fast_speed_flag);
        cmp("reset bit", 16'h0001, rd_bit);
        results();
    end
endmodule : tb_top

// [verilog/sem_core.sv]
// Copy FIFO and memory command interpreter
`timescale 1ns/10ps

module sem_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rp_q];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
            if (push && !pop) cnt_q <= cnt_q + 1'b1;
            else if (pop && !push) cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule : sem_fifo

module sem_core import sem_pkg::*; #(
    parameter int COPY_LIMIT = COPY_MAX_CYC
) (
    // Clock, reset, enable
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Slot layer strobes, same clock
    input  wire logic bus_reset,
    input  wire logic cmd_start,
    input  wire logic wr_bit_valid,
    input  wire logic wr_bit,
    input  wire logic rd_req,
    output logic      rd_valid,
    output logic      rd_bit,
    // Speed control
    input  wire logic speed_fast_set,
    input  wire logic speed_regular_set,
    output logic      fast_speed_flag,
    // Status
    output logic      partial_byte_flag,
    output logic      copy_accepted_flag,
    output logic      copy_busy
);
    sem_state_t  st_q;
    sem_state_t  st_d;
    logic [7:0]  sp_q [32];
    logic [7:0]  mem_q [512];
    logic [7:0]  sr_q;
    logic [2:0]  bcnt_q;
    logic [1:0]  idx_q;
    logic [4:0]  rbit_q;
    logic [9:0]  ptr_q;
    logic [7:0]  target_addr_low_q;
    logic [7:0]  target_addr_high_q;
    logic [4:0]  end_offset_bits_q;
    logic        pf_q;
    logic        aa_q;
    logic        bad_q;
    logic [15:0] crc_q;
    logic        alt_q;
    logic        fast_q;
    logic        busy_q;
    logic        rdv_q;
    logic        rdb_q;
    logic        pushed_q;
    logic [3:0]  nv_q;
    logic [16:0] cyc_q;
    logic        bit_v;
    logic        rd_v;
    logic        br;
    logic        rx_on;
    logic        byte_done;
    logic        rbyte_done;
    logic [7:0]  byte_val;
    logic [7:0]  es;
    logic [7:0]  cur_byte;
    logic        rd_d;
    logic        auth_ok;
    logic        cp_push;
    logic        cp_ready;
    logic        nv_valid;
    logic        nv_take;
    logic [16:0] nv_word;
    logic        copy_done;
    logic [4:0]  start_offset_bits;

    assign bit_v      = ce && wr_bit_valid;
    assign rd_v       = ce && rd_req;
    assign br         = ce && bus_reset;
    assign rx_on      = st_q inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_CP_AUTH, ST_RM_ADDR};
    assign byte_done  = bit_v && rx_on && bcnt_q == 3'h7;
    assign rbyte_done = rd_v && rbit_q[2:0] == 3'h7;
    assign byte_val   = {wr_bit, sr_q[7:1]};
    assign es = {aa_q, 1'b0, pf_q, end_offset_bits_q};
    assign start_offset_bits = target_addr_low_q[4:0];
    assign auth_ok = !bad_q && byte_val == es;

    // Bit receiver
    always_ff @(posedge clk) begin
        if (rst) begin
            sr_q   <= '0;
            bcnt_q <= '0;
        end else if (ce) begin
            if (bus_reset || cmd_start || st_d != st_q) begin
                bcnt_q <= '0;
            end else if (bit_v && rx_on) begin
                sr_q   <= byte_val;
                bcnt_q <= bcnt_q + 1'b1;
            end
        end
    end

    // Command sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (cmd_start) st_d = ST_CMD;
            ST_CMD: begin
                if (byte_done) begin
                    unique case (byte_val)
                        CMD_WRITE_SP: st_d = ST_WS_ADDR;
                        CMD_READ_SP:  st_d = ST_RS;
                        CMD_COPY_SP:  st_d = ST_CP_AUTH;
                        CMD_READ_MEM: st_d = ST_RM_ADDR;
                        default:      st_d = ST_DEAD;
                    endcase
                end
            end
            ST_WS_ADDR: if (byte_done && idx_q == 2'h1) st_d = ST_WS_DATA;
            ST_WS_DATA: if (byte_done && ptr_q[4:0] == SP_LAST) st_d = ST_WS_CRC;
            ST_CP_AUTH: begin
                if (byte_done && idx_q == 2'h2) st_d = auth_ok ? ST_CP_BUSY : ST_DEAD;
            end
            ST_CP_BUSY: if (copy_done) st_d = ST_CP_DONE;
            ST_RM_ADDR: if (byte_done && idx_q == 2'h1) st_d = ST_RM;
            ST_WS_CRC, ST_RS, ST_CP_DONE, ST_RM, ST_DEAD: st_d = st_q;
            default: st_d = ST_IDLE;
        endcase
        // Copy in progress rides through a reset; master must stay quiet
        if (bus_reset && st_q != ST_CP_BUSY) st_d = ST_IDLE;
    end

    // Busy output registered beside the state, not decoded
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
        end else if (ce) begin
            st_q   <= st_d;
            busy_q <= st_d == ST_CP_BUSY;
        end
    end

    // Byte index within a phase
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q  <= '0;
            rbit_q <= '0;
        end else if (ce) begin
            if (st_d != st_q) begin
                idx_q  <= '0;
                rbit_q <= '0;
            end else begin
                if (byte_done || (rbyte_done && st_q == ST_RS && idx_q != 2'h3)) begin
                    idx_q <= idx_q + 1'b1;
                end
                if (rd_v && !(st_q == ST_WS_CRC && rbit_q == CRC_BITS)) begin
                    rbit_q <= rbit_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            target_addr_low_q  <= '0;
            target_addr_high_q <= '0;
        end else if (byte_done && st_q inside {ST_WS_ADDR, ST_RM_ADDR}) begin
            if (idx_q == 2'h0) target_addr_low_q <= byte_val;
            else target_addr_high_q <= byte_val & ADDR_HI_MASK;
        end
    end

    // Status flags
    always_ff @(posedge clk) begin
        if (rst) begin
            end_offset_bits_q <= '0;
            pf_q              <= 1'b0;
            aa_q              <= 1'b0;
        end else begin
            if (byte_done && st_q == ST_CMD && byte_val == CMD_WRITE_SP) aa_q <= 1'b0;
            if (byte_done && st_q == ST_WS_DATA) begin
                end_offset_bits_q <= ptr_q[4:0];
                pf_q              <= 1'b0;
            end
            if (br && st_q inside {ST_WS_ADDR, ST_WS_DATA} && bcnt_q != 3'h0) pf_q <= 1'b1;
            if (byte_done && st_q == ST_CP_AUTH && idx_q == 2'h2 && auth_ok) aa_q <= 1'b1;
        end
    end

    // Authorisation mismatch memory
    always_ff @(posedge clk) begin
        if (rst) begin
            bad_q <= 1'b0;
        end else if (ce) begin
            if (st_q != ST_CP_AUTH) bad_q <= 1'b0;
            else if (byte_done && idx_q == 2'h0) bad_q <= byte_val != target_addr_low_q;
            else if (byte_done && idx_q == 2'h1) bad_q <= bad_q || byte_val != target_addr_high_q;
        end
    end

    // Shared pointer: scratchpad offset, copy offset, memory address
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q <= '0;
        end else if (ce) begin
            if (byte_done && st_q == ST_WS_ADDR && idx_q == 2'h0) begin
                ptr_q <= {5'h00, byte_val[4:0]};
            end else if (byte_done && st_q == ST_WS_DATA) begin
                ptr_q <= ptr_q + 1'b1;
            end else if (byte_done && st_q == ST_CMD) begin
                ptr_q <= {5'h00, start_offset_bits};
            end else if (byte_done && st_q == ST_CP_AUTH) begin
                ptr_q <= {5'h00, start_offset_bits};
            end else if (byte_done && st_q == ST_RM_ADDR && idx_q == 2'h1) begin
                ptr_q <= {1'b0, byte_val[0], target_addr_low_q};
            end else if (rbyte_done && st_q == ST_RS && idx_q == 2'h3 && !ptr_q[5]) begin
                ptr_q <= ptr_q + 1'b1;
            end else if (rbyte_done && st_q == ST_RM && !ptr_q[9]) begin
                ptr_q <= ptr_q + 1'b1;
            end else if (cp_push && cp_ready && ptr_q[4:0] != end_offset_bits_q) begin
                ptr_q <= {5'h00, ptr_q[4:0] + 5'h01};
            end
        end
    end

    // Scratchpad storage
    always_ff @(posedge clk) begin
        if (byte_done && st_q == ST_WS_DATA) sp_q[ptr_q[4:0]] <= byte_val;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_q <= CRC_RST;
        end else if (ce) begin
            if (cmd_start) begin
                crc_q <= CRC_RST;
            end else if (bit_v && st_q inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA}) begin
                crc_q <= (crc_q >> 1) ^ ((crc_q[0] ^ wr_bit) ? CRC_POLY : 16'h0000);
            end
        end
    end

    // Copy offsets start through end into the buffer
    assign cp_push = ce && st_q == ST_CP_BUSY && !pushed_q;
    assign nv_take = ce && nv_valid && nv_q == 4'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            pushed_q <= 1'b0;
        end else if (ce) begin
            if (st_q != ST_CP_BUSY) pushed_q <= 1'b0;
            else if (cp_push && cp_ready && ptr_q[4:0] == end_offset_bits_q) pushed_q <= 1'b1;
        end
    end

    // One byte per program time; the buffer is as deep as the scratchpad, so it never fills
    sem_fifo #(
        .W (CP_FIFO_W),
        .D (CP_FIFO_D)
    ) u_cp_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (cp_push),
        .in_ready  (cp_ready),
        .in_data   ({target_addr_high_q[0], target_addr_low_q[7:5], ptr_q[4:0], sp_q[ptr_q[4:0]]}),
        .out_valid (nv_valid),
        .out_ready (nv_q == 4'h0),
        .out_data  (nv_word)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            nv_q <= '0;
        end else if (ce) begin
            if (nv_take) nv_q <= 4'(NV_BYTE_CYC - 1);
            else if (nv_q != 4'h0) nv_q <= nv_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (nv_take) mem_q[nv_word[16:8]] <= nv_word[7:0];
    end

    assign copy_done = pushed_q && !nv_valid && nv_q == 4'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_q <= '0;
        end else if (ce) begin
            cyc_q <= st_q == ST_CP_BUSY ? cyc_q + 1'b1 : 17'h00000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alt_q <= 1'b0;
        end else if (ce) begin
            if (st_q != ST_CP_DONE) alt_q <= 1'b0;
            else if (rd_v) alt_q <= !alt_q;
        end
    end

    always_comb begin
        cur_byte = DATA_ONES;
        if (st_q == ST_RS) begin
            unique case (idx_q)
                2'h0: cur_byte = target_addr_low_q;
                2'h1: cur_byte = target_addr_high_q;
                2'h2: cur_byte = es;
                2'h3: cur_byte = ptr_q[5] ? DATA_ONES : sp_q[ptr_q[4:0]];
            endcase
        end else if (st_q == ST_RM) begin
            cur_byte = ptr_q[9] ? DATA_ONES : mem_q[ptr_q[8:0]];
        end
    end

    always_comb begin
        rd_d = 1'b1;
        unique case (st_q)
            ST_WS_CRC:  rd_d = rbit_q < CRC_BITS ? !crc_q[rbit_q[3:0]] : 1'b1;
            ST_CP_DONE: rd_d = alt_q;
            ST_RS, ST_RM: rd_d = cur_byte[rbit_q[2:0]];
            default:    rd_d = 1'b1;
        endcase
    end

    // Registered read answer
    always_ff @(posedge clk) begin
        if (rst) begin
            rdv_q <= 1'b0;
            rdb_q <= 1'b1;
        end else if (ce) begin
            rdv_q <= rd_req;
            if (rd_req) rdb_q <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fast_q <= 1'b0;
        end else if (ce) begin
            if (speed_regular_set) fast_q <= 1'b0;
            else if (speed_fast_set) fast_q <= 1'b1;
        end
    end

    assign rd_valid           = rdv_q;
    assign rd_bit             = rdb_q;
    assign fast_speed_flag    = fast_q;
    assign partial_byte_flag  = pf_q;
    assign copy_accepted_flag = aa_q;
    assign copy_busy          = busy_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_addr_trunc: assert property (target_addr_high_q[7:1] == 7'h00)
        else $error("upper address bits not cleared");
    chk_write_clears_aa: assert property (
        byte_done && st_q == ST_CMD && byte_val == CMD_WRITE_SP |=> !aa_q)
        else $error("write command kept accepted flag");
    chk_partial_set: assert property (
        br && st_q == ST_WS_DATA && bcnt_q != 3'h0 |=> pf_q && st_q == ST_IDLE)
        else $error("partial byte not flagged");
    chk_end_offset: assert property (
        byte_done && st_q == ST_WS_DATA |=> end_offset_bits_q == $past(ptr_q[4:0]) && !pf_q)
        else $error("ending offset wrong");
    chk_crc_inverted: assert property (
        rd_v && st_q == ST_WS_CRC && rbit_q < CRC_BITS
        |=> rd_valid && rd_bit == !$past(crc_q[rbit_q[3:0]]))
        else $error("CRC bit not inverted");
    chk_ones_past_end: assert property (
        rd_v && st_q == ST_RS && idx_q == 2'h3 && ptr_q[5] |=> rd_bit)
        else $error("scratchpad overrun not ones");
    chk_copy_time: assert property (cyc_q < 17'(COPY_LIMIT))
        else $error("copy exceeded time limit");
    chk_auth_accept: assert property (
        byte_done && st_q == ST_CP_AUTH && idx_q == 2'h2 && auth_ok
        |=> aa_q && st_q == ST_CP_BUSY)
        else $error("matching authorisation not accepted");
    chk_auth_refuse: assert property (
        byte_done && st_q == ST_CP_AUTH && idx_q == 2'h2 && !auth_ok
        |=> st_q == ST_DEAD && !$rose(aa_q))
        else $error("bad authorisation accepted");
    chk_es_keep: assert property (
        st_q inside {ST_RM_ADDR, ST_RM} && !br |=> $stable(es))
        else $error("read memory altered status");
    chk_alt_pattern: assert property (
        rd_v && st_q == ST_CP_DONE ##1 !rd_v ##1 rd_v && st_q == ST_CP_DONE
        |=> rd_bit != $past(rd_bit, 2))
        else $error("copy done pattern not alternating");

    cov_copy_done: cover property (st_q == ST_CP_BUSY ##1 st_q == ST_CP_DONE);
    cov_crc_read:  cover property (st_q == ST_WS_CRC && rbit_q == CRC_BITS);
    cov_mem_end:   cover property (st_q == ST_RM && ptr_q[9] && rd_v);
endmodule : sem_core

// [verilog/sem_pkg.sv]
// Constants and states of the memory command layer
package sem_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
    localparam logic [7:0] CMD_READ_SP  = 8'hAA;
    localparam logic [7:0] CMD_COPY_SP  = 8'h55;
    localparam logic [7:0] CMD_READ_MEM = 8'hF0;
    // Field layout
    localparam logic [7:0] ADDR_HI_MASK = 8'h01;
    localparam logic [4:0] SP_LAST      = 5'h1F;
    localparam int         ES_PF_BIT    = 5;
    localparam int         ES_AA_BIT    = 7;
    localparam logic [7:0] DATA_ONES    = 8'hFF;
    // CRC16, reflected form of x16+x15+x2+1
    localparam logic [15:0] CRC_POLY    = 16'hA001;
    localparam logic [15:0] CRC_RST     = 16'h0000;
    localparam logic [4:0]  CRC_BITS    = 5'h10;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int COPY_MAX_NS   = 5000000;
    localparam int COPY_MAX_CYC  = COPY_MAX_NS / CLK_PERIOD_NS;
    localparam int NV_BYTE_NS    = 1000;
    localparam int NV_BYTE_CYC   = (NV_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Copy path buffer
    localparam int CP_FIFO_W     = 17;
    localparam int CP_FIFO_D     = 32;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_CMD     = 4'b0001,
        ST_WS_ADDR = 4'b0010,
        ST_WS_DATA = 4'b0011,
        ST_WS_CRC  = 4'b0100,
        ST_RS      = 4'b0101,
        ST_CP_AUTH = 4'b0110,
        ST_CP_BUSY = 4'b0111,
        ST_CP_DONE = 4'b1000,
        ST_RM_ADDR = 4'b1001,
        ST_RM      = 4'b1010,
        ST_DEAD    = 4'b1011
    } sem_state_t;
endpackage : sem_pkg
